// >>> rtl/spu_top.sv
// Purpose: apb register side of the single-pin uart
// Assumes: one clock REF_CLK; pin inputs synchronised here
// Notes: zero-wait apb slave; unmapped reads return zero
`timescale 1ns/1ns
// Function
// RL1: while busy, writes to control, divisor and tx holding are ignored
// RL2: busy sets when the serial side starts work, clears when ready
// RL3: a one in status clear clears that flag and its interrupt
// RL4: zeros written to clear, enable or disable registers do nothing
// RL5: a one in irq enable set sets that mask bit only
// RL6: a one in irq enable clear clears that mask bit only
// RL7: irq mask state reads one per enabled source, status layout
// RL8: rx holding shows the last byte received, upper bits zero
// RL9: the low byte written to tx holding is the next byte sent
// RL10: bit rate is eight times oscillator frequency over the divisor
// RL11: software should not program a divisor below 32
// RL12: a divisor write changes the rate for following transfers
// RL13: divisor reads return the value in use, possibly hardware-set
// RL14: revision register is a fixed read-only 12-bit number
// RL15: clock request zero stops the link clock, one starts it
// RL16: resync mode measures a first 0x55 byte and sets the divisor
// RL17: an enabled interrupt fires on its flag's rising edge
// RL18: overrun replaces the unread byte and sets the overrun flag
// RL19: interrupt output is high while any enabled flag is set
module spu_top #(
	parameter logic [11:0] REVISION = spu_pkg::SPU_REVISION_DEFAULT // arbitrary value
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic LINE_IN,
	output logic LINE_OUT,
	output logic LINE_OE_N,
	output logic IRQ
);
	logic line_meta_q;
	logic line_sync_q;
	logic [1:0] mode_q;
	logic [15:0] divisor_q;
	logic [7:0] tx_byte_q;
	logic [7:0] rx_byte_q;
	logic rx_unread_q;
	logic link_clock_on_q;
	logic tx_go_q;
	logic tx_mismatch_flag_q;
	logic overrun_q;
	logic rx_byte_flag_q;
	logic idle_again_flag_q;
	logic [31:0] mask_q;
	logic busy_prev_q;
	logic sync_done_q;
	logic sync_run_q;
	logic [20:0] sync_cnt_q;
	logic [3:0] sync_edges_q;
	logic sync_prev_q;
	logic wr;
	logic rd;
	logic ser_busy;
	logic busy;
	logic rx_done;
	logic [7:0] rx_data;
	logic mismatch;
	logic bit_tick;
	logic ser_ce;
	logic rx_en;
	logic [31:0] status;
	logic [31:0] wmask;
	logic [31:0] rdata;
	logic ser_oe_n;
	logic irq_d;
	assign wr = PSEL && PENABLE && PWRITE;
	assign rd = PSEL && PENABLE && !PWRITE;
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;
	assign LINE_OUT = 1'b0;
	assign wmask = PWDATA & spu_pkg::SPU_IRQ_BITS;
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			line_meta_q <= 1'b1;
			line_sync_q <= 1'b1;
		end else if (CE) begin
			line_meta_q <= LINE_IN;
			line_sync_q <= line_meta_q;
		end
	end
	// link clock gated by the request bit: serial side freezes when off
	assign ser_ce = CE && link_clock_on_q; // see RL15
	assign rx_en = (mode_q == spu_pkg::SPU_MODE_RX) ||
		(mode_q == spu_pkg::SPU_MODE_RX_SYNC && sync_done_q);
	// sync measurement owns the line until the first byte is measured
	assign busy = ser_busy || tx_go_q || sync_run_q; // see RL2
	spu_tick u_tick (
		.clk(REF_CLK),
		.rst(RST),
		.ce(ser_ce),
		.restart(!ser_busy), // idle holds the bit phase; a free-running phase can sample on edges
		.divisor(divisor_q), // see RL12
		.tick(bit_tick) // see RL10
	);
	spu_serial u_serial (
		.clk(REF_CLK),
		.rst(RST),
		.ce(ser_ce),
		.bit_tick(bit_tick),
		.rx_en(rx_en),
		.tx_go(tx_go_q),
		.tx_data(tx_byte_q), // see RL9
		.line_in(line_sync_q),
		.line_oe_n(ser_oe_n),
		.busy(ser_busy),
		.rx_done(rx_done),
		.rx_data(rx_data),
		.mismatch(mismatch)
	);
	assign LINE_OE_N = ser_oe_n;
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			mode_q <= 2'h0;
			tx_byte_q <= 8'h00;
			tx_go_q <= 1'b0;
		end else if (CE) begin
			if (ser_busy || !ser_ce) begin
				tx_go_q <= tx_go_q & ~ser_busy;
			end
			if (wr && !busy) begin // see RL1
				if (PADDR == spu_pkg::SPU_OFS_CTRL) begin
					mode_q <= PWDATA[1:0];
				end
				if (PADDR == spu_pkg::SPU_OFS_TX_HOLDING &&
						mode_q == spu_pkg::SPU_MODE_TX) begin
					tx_byte_q <= PWDATA[7:0]; // see RL9
					tx_go_q <= 1'b1;
				end
			end
		end
	end
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			link_clock_on_q <= 1'b0;
		end else if (CE && wr && PADDR == spu_pkg::SPU_OFS_CLOCK_REQUEST) begin
			link_clock_on_q <= PWDATA[0]; // see RL15
		end
	end
	// resync: time 8 bits of 0x55 = 8 bit periods; divisor = 8*clocks/bit = clocks total
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			divisor_q <= spu_pkg::SPU_DIVISOR_RESET;
			sync_done_q <= 1'b0;
			sync_run_q <= 1'b0;
			sync_cnt_q <= '0;
			sync_edges_q <= '0;
			sync_prev_q <= 1'b1;
		end else if (CE) begin
			sync_prev_q <= line_sync_q;
			if (mode_q != spu_pkg::SPU_MODE_RX_SYNC) begin
				sync_done_q <= 1'b0;
				sync_run_q <= 1'b0;
			end else if (!sync_done_q && ser_ce) begin // see RL16
				if (!sync_run_q && sync_prev_q && !line_sync_q) begin
					sync_run_q <= 1'b1;
					sync_cnt_q <= '0;
					sync_edges_q <= '0;
				end else if (sync_run_q) begin
					sync_cnt_q <= sync_cnt_q + 21'h1;
					// stay busy through the low last bit, else it looks like a start bit
					if (sync_edges_q == 4'h4) begin
						if (line_sync_q) begin
							sync_run_q <= 1'b0;
							sync_done_q <= 1'b1;
						end
					// start bit plus 0x55 gives five falling edges; last starts bit 8
					end else if (sync_prev_q && !line_sync_q) begin
						sync_edges_q <= sync_edges_q + 4'h1;
						if (sync_edges_q == 4'h3) begin
							divisor_q <= sync_cnt_q[15:0] + 16'h1; // see RL13
						end
					end
				end
			end
			if (wr && !busy && PADDR == spu_pkg::SPU_OFS_BAUD_DIVISOR) begin
				divisor_q <= PWDATA[15:0]; // see RL1 see RL12
			end
		end
	end
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			rx_byte_q <= 8'h00;
			rx_unread_q <= 1'b0;
		end else if (CE) begin
			if (rd && PADDR == spu_pkg::SPU_OFS_RX_HOLDING) begin
				rx_unread_q <= 1'b0;
			end
			if (rx_done) begin
				rx_byte_q <= rx_data; // see RL18
				rx_unread_q <= 1'b1;
			end
		end
	end
	// flags: hardware set wins over a same-cycle software clear
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			tx_mismatch_flag_q <= 1'b0;
			overrun_q <= 1'b0;
			rx_byte_flag_q <= 1'b0;
			idle_again_flag_q <= 1'b0;
			busy_prev_q <= 1'b0;
		end else if (CE) begin
			busy_prev_q <= busy;
			if (wr && PADDR == spu_pkg::SPU_OFS_STATUS_CLEAR) begin // see RL3 see RL4
				if (wmask[spu_pkg::SPU_BIT_TX_MISMATCH]) tx_mismatch_flag_q <= 1'b0;
				if (wmask[spu_pkg::SPU_BIT_OVERRUN]) overrun_q <= 1'b0;
				if (wmask[spu_pkg::SPU_BIT_RX_BYTE]) rx_byte_flag_q <= 1'b0;
				if (wmask[spu_pkg::SPU_BIT_IDLE_AGAIN]) idle_again_flag_q <= 1'b0;
			end
			if (mismatch) tx_mismatch_flag_q <= 1'b1;
			if (rx_done && rx_unread_q) overrun_q <= 1'b1; // see RL18
			if (rx_done) rx_byte_flag_q <= 1'b1;
			if (busy_prev_q && !busy) idle_again_flag_q <= 1'b1;
		end
	end
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			mask_q <= 32'h0000_0000;
		end else if (CE && wr) begin
			if (PADDR == spu_pkg::SPU_OFS_IRQ_ENABLE_SET) begin
				mask_q <= mask_q | wmask; // see RL5 see RL4
			end else if (PADDR == spu_pkg::SPU_OFS_IRQ_ENABLE_CLEAR) begin
				mask_q <= mask_q & ~wmask; // see RL6 see RL4
			end
		end
	end
	always_comb begin
		status = 32'h0000_0000;
		status[spu_pkg::SPU_BIT_BUSY] = busy;
		status[spu_pkg::SPU_BIT_CLK_RUNNING] = link_clock_on_q;
		status[spu_pkg::SPU_BIT_IDLE_AGAIN] = idle_again_flag_q;
		status[spu_pkg::SPU_BIT_RX_BYTE] = rx_byte_flag_q;
		status[spu_pkg::SPU_BIT_OVERRUN] = overrun_q;
		status[spu_pkg::SPU_BIT_TX_MISMATCH] = tx_mismatch_flag_q;
	end
	// level output follows flag and mask; a rising flag raises it
	assign irq_d = |(status & mask_q & spu_pkg::SPU_IRQ_BITS); // see RL17 see RL19
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			IRQ <= 1'b0;
		end else if (CE) begin
			IRQ <= irq_d;
		end
	end
	always_comb begin
		rdata = 32'h0000_0000;
		unique case (PADDR)
			spu_pkg::SPU_OFS_CTRL: rdata = {30'h0, mode_q};
			spu_pkg::SPU_OFS_STATUS: rdata = status;
			spu_pkg::SPU_OFS_IRQ_MASK_STATE: rdata = mask_q; // see RL7
			spu_pkg::SPU_OFS_RX_HOLDING: rdata = {24'h0, rx_byte_q}; // see RL8
			spu_pkg::SPU_OFS_TX_HOLDING: rdata = {24'h0, tx_byte_q};
			spu_pkg::SPU_OFS_BAUD_DIVISOR: rdata = {16'h0, divisor_q}; // see RL13
			spu_pkg::SPU_OFS_MODULE_REVISION: rdata = {20'h0, REVISION}; // see RL14
			spu_pkg::SPU_OFS_CLOCK_REQUEST: rdata = {31'h0, link_clock_on_q};
			default: rdata = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			PRDATA <= 32'h0000_0000;
		end else if (CE && PSEL && !PENABLE && !PWRITE) begin
			PRDATA <= rdata;
		end
	end
endmodule : spu_top

// >>> rtl/spu_pkg.sv
// Purpose: shared constants for the single-pin uart register block
// Assumes: apb with 32-bit data, byte offsets as printed
// Notes: status, clear, enable, disable and mask share one bit layout
package spu_pkg;
	localparam logic [7:0] SPU_OFS_CTRL = 8'h00;
	localparam logic [7:0] SPU_OFS_STATUS = 8'h04;
	localparam logic [7:0] SPU_OFS_STATUS_CLEAR = 8'h08;
	localparam logic [7:0] SPU_OFS_IRQ_ENABLE_SET = 8'h0C;
	localparam logic [7:0] SPU_OFS_IRQ_ENABLE_CLEAR = 8'h10;
	localparam logic [7:0] SPU_OFS_IRQ_MASK_STATE = 8'h14;
	localparam logic [7:0] SPU_OFS_RX_HOLDING = 8'h18;
	localparam logic [7:0] SPU_OFS_TX_HOLDING = 8'h1C;
	localparam logic [7:0] SPU_OFS_BAUD_DIVISOR = 8'h20;
	localparam logic [7:0] SPU_OFS_MODULE_REVISION = 8'h24;
	localparam logic [7:0] SPU_OFS_CLOCK_REQUEST = 8'h28;
	localparam int SPU_BIT_BUSY = 0;
	localparam int SPU_BIT_CLK_RUNNING = 2;
	localparam int SPU_BIT_IDLE_AGAIN = 8;
	localparam int SPU_BIT_RX_BYTE = 9;
	localparam int SPU_BIT_OVERRUN = 10;
	localparam int SPU_BIT_TX_MISMATCH = 13;
	localparam logic [31:0] SPU_IRQ_BITS = 32'h0000_2700;
	localparam logic [15:0] SPU_DIVISOR_RESET = 16'h0000;
	localparam logic [15:0] SPU_DIVISOR_DEFAULT = 16'h0020;
	localparam logic [11:0] SPU_REVISION_DEFAULT = 12'h123;
	localparam logic [7:0] SPU_SYNC_BYTE = 8'h55;
	localparam int SPU_OVERSAMPLE = 8;
	typedef enum logic [1:0] {
		SPU_MODE_OFF,
		SPU_MODE_RX,
		SPU_MODE_TX,
		SPU_MODE_RX_SYNC
	} spu_mode_t;
endpackage : spu_pkg

// >>> rtl/spu_tick.sv
// Purpose: bit-rate tick generator, one tick per bit, steps of eight per clock
// Assumes: one clock stands for the fast oscillator
// Notes: a divisor change takes effect on the next tick
`timescale 1ns/1ns
module spu_tick (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic restart,
	input wire logic [15:0] divisor,
	output logic tick
);
	logic [18:0] acc_q;
	logic [18:0] sum;
	assign sum = acc_q + 19'(spu_pkg::SPU_OVERSAMPLE);
	// rate = 8 * f / divisor: accumulate 8 per clock, tick per divisor
	always_ff @(posedge clk) begin
		if (rst) begin
			acc_q <= '0;
			tick <= 1'b0;
		end else if (ce) begin
			if (restart) begin
				// half a bit preloaded so receive samples land mid-bit, not on edges
				acc_q <= {4'h0, divisor[15:1]};
				tick <= 1'b0;
			end else if (divisor != 16'h0000 && sum >= {3'h0, divisor}) begin
				acc_q <= sum - {3'h0, divisor};
				tick <= 1'b1;
			end else begin
				acc_q <= sum;
				tick <= 1'b0;
			end
		end
	end
endmodule : spu_tick

// >>> rtl/spu_serial.sv
// Purpose: half-duplex byte shifter on one open-drain wire
// Assumes: line input already synchronised; 8N1 framing, lsb first
// Notes: reports busy, byte received, and line mismatch while sending
`timescale 1ns/1ns
module spu_serial (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic bit_tick,
	input wire logic rx_en,
	input wire logic tx_go,
	input wire logic [7:0] tx_data,
	input wire logic line_in,
	output logic line_oe_n,
	output logic busy,
	output logic rx_done,
	output logic [7:0] rx_data,
	output logic mismatch
);
	typedef enum logic [1:0] {SPU_IDLE, SPU_SEND, SPU_RECV} spu_ser_t;
	spu_ser_t state_q;
	logic [9:0] shift_q;
	logic [3:0] bits_q;
	assign busy = state_q != SPU_IDLE;
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= SPU_IDLE;
			shift_q <= '0;
			bits_q <= '0;
			line_oe_n <= 1'b1;
			rx_done <= 1'b0;
			rx_data <= '0;
			mismatch <= 1'b0;
		end else if (ce) begin
			rx_done <= 1'b0;
			mismatch <= 1'b0;
			unique case (state_q)
				SPU_IDLE: begin
					if (tx_go) begin
						shift_q <= {1'b1, tx_data, 1'b0};
						bits_q <= 4'h0;
						state_q <= SPU_SEND;
					end else if (rx_en && !line_in) begin
						bits_q <= 4'h0;
						state_q <= SPU_RECV;
					end
				end
				SPU_SEND: if (bit_tick) begin
					// pulling low drives the wire; a low seen while released is a clash
					mismatch <= line_oe_n && !line_in;
					line_oe_n <= shift_q[0];
					shift_q <= {1'b1, shift_q[9:1]};
					bits_q <= bits_q + 4'h1;
					if (bits_q == 4'h9) begin
						line_oe_n <= 1'b1;
						state_q <= SPU_IDLE;
					end
				end
				SPU_RECV: if (bit_tick) begin
					// samples once per tick at mid-bit, coarse but divisor-true
					shift_q <= {line_in, shift_q[9:1]};
					bits_q <= bits_q + 4'h1;
					if (bits_q == 4'h9) begin
						rx_data <= shift_q[9:2];
						rx_done <= 1'b1;
						state_q <= SPU_IDLE;
					end
				end
				default: state_q <= SPU_IDLE;
			endcase
		end
	end
endmodule : spu_serial

// >>> test/spu_checker.sv
// Purpose: port-level assertions for the single-pin uart register block
// Assumes: zero-wait apb, read data loaded in the setup cycle
// Notes: mask and link clock state are shadowed from bus writes
`timescale 1ns/1ns
module spu_checker #(
	parameter logic [11:0] REVISION = 12'h000
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic LINE_IN,
	input wire logic LINE_OUT,
	input wire logic LINE_OE_N,
	input wire logic IRQ
);
	logic [31:0] mask_q;
	logic clk_on_q;
	wire wr_now = CE && PSEL && PENABLE && PWRITE;
	wire rd_now = PSEL && PENABLE && !PWRITE;
	always_ff @(posedge REF_CLK) begin
		if (RST)
			mask_q <= '0;
		else if (wr_now && PADDR == 8'h0C)
			mask_q <= mask_q | (PWDATA & spu_pkg::SPU_IRQ_BITS);
		else if (wr_now && PADDR == 8'h10)
			mask_q <= mask_q & ~PWDATA;
	end
	// the clock request is not blocked by busy, unlike divisor and tx writes
	always_ff @(posedge REF_CLK) begin
		if (RST)
			clk_on_q <= 1'b0;
		else if (wr_now && PADDR == 8'h28)
			clk_on_q <= PWDATA[0];
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	chk_reset_state: assert property ($fell(RST) |-> PRDATA == 32'h0 && LINE_OE_N && !IRQ)
		else $error("outputs not at reset level");
	chk_link_off: assert property (!clk_on_q && !$past(clk_on_q) |-> LINE_OE_N)
		else $error("wire pulled with link clock off");
	chk_rx_upper: assert property (rd_now && PADDR == 8'h18 |-> PRDATA[31:8] == 24'h0)
		else $error("rx holding upper bits set");
	chk_rev_read: assert property (rd_now && PADDR == 8'h24 |-> PRDATA == {20'h0, REVISION})
		else $error("revision read wrong");
	chk_mask_read: assert property (rd_now && PADDR == 8'h14 |-> PRDATA == mask_q)
		else $error("mask read wrong");
	chk_zero_wait: assert property (PSEL |-> PREADY && !PSLVERR)
		else $error("bus answer not ready or error");
	chk_irq_masked: assert property (mask_q == 0 && $past(mask_q) == 0 |-> !IRQ)
		else $error("interrupt with all sources masked");
	chk_open_drain: assert property (LINE_OUT == 1'b0)
		else $error("wire data not low");
	chk_bit_min: assert property ($fell(LINE_OE_N) |-> !LINE_OE_N [*4])
		else $error("low bit shorter than four clocks");
	cover property ($rose(IRQ));
	cover property ($fell(LINE_OE_N));
	cover property (rd_now && PADDR == 8'h14);
endmodule : spu_checker
bind spu_top spu_checker #(.REVISION(REVISION)) u_chk (.REF_CLK(REF_CLK), .RST(RST), .CE(CE),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LINE_IN(LINE_IN),
	.LINE_OUT(LINE_OUT), .LINE_OE_N(LINE_OE_N), .IRQ(IRQ));

// >>> test/spu_link_model.sv
// Purpose: far-side programmer on the single open-drain wire
// Assumes: 8N1 framing, lsb first, bit time given in clocks
// Notes: releases the wire between frames so the pull-up wins
`timescale 1ns/1ns
module spu_link_model (
	input wire logic clk,
	input wire logic line,
	output logic pull_n
);
	initial pull_n = 1'b1;
	task automatic send(input logic [7:0] b, input int per);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			pull_n <= f[i];
			repeat (per) @(posedge clk);
		end
	endtask : send
	// holds the wire at a level, to clash with the device while it sends
	task automatic hold(input logic v);
		pull_n <= v;
	endtask : hold
	// samples mid-bit, so one clock of skew on the start edge is tolerated
	task automatic recv(output logic [7:0] b, input int per);
		int n;
		n = 0;
		while (line !== 1'b0 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		repeat (per / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (per) @(posedge clk);
			b[i] = line;
		end
	endtask : recv
endmodule : spu_link_model

// >>> test/tb.sv
// Purpose: self-checking bench for the single-pin uart register block
// Assumes: apb master tasks, link model on a pulled-up wire
// Notes: CE held high; divisor kept at 32 or more
`timescale 1ns/1ns
module tb;
	localparam logic [11:0] rev = 12'h5A1; // arbitrary value
	localparam logic [31:0] all_ones = 32'hFFFF_FFFF;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, line_out, line_oe_n, irq, pull_n;
	logic [7:0] rxb;
	logic [7:0] ofs [9] = '{8'h00, 8'h04, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h28, 8'h2C, 8'h24};
	wire line = pull_n & line_oe_n;
	int error_cnt = 0;
	int check_count = 0;
	always #50 clk = ~clk;
	spu_top #(.REVISION(rev)) uut (.REF_CLK(clk), .RST(rst), .CE(1'b1), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .LINE_IN(line), .LINE_OUT(line_out),
		.LINE_OE_N(line_oe_n), .IRQ(irq));
	spu_link_model link (.clk(clk), .line(line), .pull_n(pull_n));
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n >= 20) begin
			chk(32'h0, 32'h1, "bus wait ran out");
			close_out();
		end
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd & m, e, $sformatf("read %h", a));
	endtask : rc
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			xfer(1'b0, 8'h04, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 200);
		if (n >= 200) begin
			chk(32'h0, 32'h1, "busy wait ran out");
			close_out();
		end
	endtask : wait_idle
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 9; i++) rc(ofs[i], all_ones, i == 8 ? {20'h0, rev} : 32'h0);
		$display("reset values done");
		wr(8'h0C, all_ones);
		rc(8'h14, all_ones, 32'h0000_2700);
		wr(8'h10, 32'h0000_0100);
		rc(8'h14, all_ones, 32'h0000_2600);
		wr(8'h0C, 32'h0);
		wr(8'h10, 32'h0);
		wr(8'h08, 32'h0);
		rc(8'h14, all_ones, 32'h0000_2600);
		$display("mask test done");
		// divisor 32 is the smallest that software may program
		wr(8'h28, 32'h1);
		wr(8'h20, 32'h20);
		wr(8'h00, 32'h2);
		fork
			link.recv(rxb, 4);
			begin
				wr(8'h1C, 32'hFFFF_FFA5);
				rc(8'h04, 32'h1, 32'h1);
				wr(8'h20, 32'h40);
				rc(8'h20, all_ones, 32'h20);
			end
		join
		chk({24'h0, rxb}, 32'hA5, "sent byte");
		wait_idle();
		rc(8'h04, 32'h100, 32'h100);
		chk({31'h0, irq}, 32'h0, "masked irq");
		wr(8'h0C, 32'h100);
		@(posedge clk);
		chk({31'h0, irq}, 32'h1, "irq up");
		wr(8'h08, 32'h100);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		$display("transmit test done");
		wr(8'h20, 32'h40);
		wr(8'h00, 32'h1);
		link.send(8'h3C, 8);
		link.send(8'hC3, 8);
		repeat (8) @(posedge clk);
		rc(8'h04, 32'h600, 32'h600);
		chk({31'h0, irq}, 32'h1, "rx irq");
		rc(8'h18, all_ones, 32'hC3);
		wr(8'h08, 32'h700);
		rc(8'h04, 32'h600, 32'h0);
		$display("receive test done");
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h3);
		link.send(8'h55, 6);
		repeat (8) @(posedge clk);
		xfer(1'b0, 8'h20, 32'h0);
		chk(32'(rd > 46 && rd < 50), 32'h1, "measured divisor");
		link.send(8'h96, 6);
		repeat (8) @(posedge clk);
		rc(8'h18, all_ones, 32'h96);
		$display("resync test done");
		wr(8'h00, 32'h2);
		link.hold(1'b0);
		wr(8'h1C, 32'h5A);
		wait_idle();
		rc(8'h04, 32'h2000, 32'h2000);
		wr(8'h08, 32'h2000);
		rc(8'h04, 32'h2000, 32'h0);
		link.hold(1'b1);
		$display("mismatch test done");
		close_out();
	end
endmodule : tb
